// File: hdl/mode_cfg_pkg.sv
package mode_cfg_pkg;
	// serial framing
	localparam int          CMD_BITS      = 8;
	localparam int          DATA_BITS     = 16;
	localparam int          CNT_W         = 5;
	localparam logic [4:0]  MODE_ADDR     = 5'h06;
	localparam int          CMD_DIR_BIT   = 7;
	localparam int          CMD_ADDR_MSB  = 4;
	// mode register fields
	localparam int          HPF_BYP_BIT   = 0;
	localparam int          FACT_LO_BIT   = 1;
	localparam int          PULSE_OFF_BIT = 2;
	localparam int          DIP_OFF_BIT   = 3;
	localparam int          THERM_GO_BIT  = 5;
	localparam int          SOFT_RST_BIT  = 6;
	localparam int          CAL_SEL_BIT   = 7;
	localparam int          SHORT1_BIT    = 8;
	localparam int          SHORT2_BIT    = 9;
	localparam int          SWAP_BIT      = 10;
	localparam int          RATE_LSB      = 11;
	localparam int          SRC_LSB       = 13;
	localparam int          FACT_HI_BIT   = 15;
	localparam logic [15:0] MODE_RESET    = 16'h0000;
	// bit 4 reserved and bit 6 self-acting: never stored
	localparam logic [15:0] STORE_MASK    = 16'hFFAF;
	// soft reset quiet time
	localparam int          CLK_PERIOD_PS = 10000;
	localparam int          QUIET_TIME_PS = 18000000;
	localparam int          QUIET_CYCLES  = (QUIET_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          QUIET_W       = 11;
	// waveform update divisors
	localparam int          RATE_W        = 10;
	localparam int          DIV_128       = 128;
	localparam int          DIV_256       = 256;
	localparam int          DIV_512       = 512;
	localparam int          DIV_1024      = 1024;

	typedef enum logic [1:0] {
		SRC_POWER,
		SRC_RESERVED,
		SRC_CH1,
		SRC_CH2
	} wave_src_t;

	typedef enum {
		ST_CMD,
		ST_WRITE,
		ST_READ,
		ST_SKIP
	} ser_state_t;

	// last count value for a rate code
	function automatic logic [RATE_W-1:0] rate_term(input logic [1:0] code);
		case (code)
			2'b00:   rate_term = RATE_W'(DIV_128 - 1);
			2'b01:   rate_term = RATE_W'(DIV_256 - 1);
			2'b10:   rate_term = RATE_W'(DIV_512 - 1);
			default: rate_term = RATE_W'(DIV_1024 - 1);
		endcase
	endfunction

	// source code to sampled signal
	function automatic wave_src_t src_decode(input logic [1:0] code);
		case (code)
			2'b00:   src_decode = SRC_POWER;
			2'b10:   src_decode = SRC_CH1;
			2'b11:   src_decode = SRC_CH2;
			default: src_decode = SRC_RESERVED;
		endcase
	endfunction
endpackage

// File: hdl/wave_ctl_if.sv
`timescale 1ns/1ps
interface wave_ctl_if;
	import mode_cfg_pkg::*;
	logic [1:0] rate_sel;
	logic [1:0] source_sel;
	logic       sample_stb;
	wave_src_t  source;
	logic       source_valid;

	modport cfg (output rate_sel, output source_sel, input sample_stb, input source,
		input source_valid);
	modport timer (input rate_sel, input source_sel, output sample_stb, output source,
		output source_valid);
endinterface

// File: hdl/wave_timer.sv
`timescale 1ns/1ps
module wave_timer (
	input  wire logic   clk,
	input  wire logic   rstn,
	wave_ctl_if.timer   wv
);
	import mode_cfg_pkg::*;

	logic [RATE_W-1:0] cnt_q;
	logic [RATE_W-1:0] cnt_d;
	logic              stb_q;
	logic              stb_d;
	wave_src_t         src_q;
	wave_src_t         src_d;
	logic              valid_q;
	logic              valid_d;

	////////////////////////////////////////////////////////////////
	// update rate divider and source decode
	always_comb begin
		stb_d   = 1'b0;
		cnt_d   = RATE_W'(cnt_q + 1'b1);
		if (cnt_q >= rate_term(wv.rate_sel)) begin
			cnt_d = '0;
			stb_d = 1'b1;
		end
		src_d   = src_decode(wv.source_sel);
		valid_d = (src_d != SRC_RESERVED);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_q   <= '0;
			stb_q   <= 1'b0;
			src_q   <= SRC_POWER;
			valid_q <= 1'b1;
		end else begin
			cnt_q   <= cnt_d;
			stb_q   <= stb_d;
			src_q   <= src_d;
			valid_q <= valid_d;
		end
	end

	assign wv.sample_stb   = stb_q;
	assign wv.source       = src_q;
	assign wv.source_valid = valid_q;

	////////////////////////////////////////////////////////////////
	// checks
	rate_min_gap_a: assert property (@(posedge clk) disable iff (!rstn)
		stb_q |=> !stb_q [*8]) else $error("waveform strobes too close");
	rate_slow_gap_a: assert property (@(posedge clk) disable iff (!rstn)
		(stb_q && wv.rate_sel == 2'b11 && $stable(wv.rate_sel)) ##1 wv.rate_sel == 2'b11 [*8]
		|-> !stb_q) else $error("slow rate strobe early");
	src_ch1_a: assert property (@(posedge clk) disable iff (!rstn)
		wv.source_sel == 2'b10 |=> src_q == SRC_CH1 && valid_q) else $error("ch1 source wrong");
	src_reserved_a: assert property (@(posedge clk) disable iff (!rstn)
		wv.source_sel == 2'b01 |=> !valid_q) else $error("reserved source valid");
	src_power_a: assert property (@(posedge clk) disable iff (!rstn)
		wv.source_sel == 2'b00 |=> src_q == SRC_POWER) else $error("power source wrong");
endmodule // wave_timer

// File: hdl/energy_meter_mode_config.sv
// Function
// - mode bit 0 set bypasses channel 1 high-pass filter.
// - mode bit 2 set turns off the frequency pulse output.
// - mode bit 3 set suppresses line-voltage dip detection.
// - writing bit 5 starts thermal conversion; bit clears when done.
// - bit 6 resets the chip; host stays quiet for 18 us.
// - mode bit 7 selects calibration mode, else normal measurement.
// - bits 8 and 9 short converter 1 and converter 2 inputs.
// - bit 10 swaps analog input pairs between the converters.
// - bits 12..11 pick waveform rate clk/128, /256, /512, /1024.
// - bits 14..13 pick the waveform sample source.
// - source 00 power, 10 channel 1, 11 channel 2, 01 reserved.
// - command byte top bit selects write or read, data follows.
`timescale 1ns/1ps
module energy_meter_mode_config (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    sclk,
	input  wire logic                    din,
	input  wire logic                    cs_n,
	output      logic                    dout,
	output      logic                    dout_oe,
	input  wire logic                    pulse_raw,
	output      logic                    frequency_pulse_out,
	input  wire logic                    dip_raw,
	output      logic                    dip_event,
	input  wire logic                    temp_conv_done,
	output      logic                    ch1_highpass_bypass,
	output      logic                    pulse_output_off,
	output      logic                    dip_detect_off,
	output      logic                    thermal_conv_go,
	output      logic                    soft_chip_reset,
	output      logic                    calibration_select,
	output      logic                    conv1_input_short,
	output      logic                    conv2_input_short,
	output      logic                    input_swap,
	output      logic                    factory_bit_low,
	output      logic                    factory_bit_high,
	output      logic [1:0]              waveform_rate_sel,
	output      logic [1:0]              waveform_source_sel,
	output      logic                    waveform_sample_stb,
	output      mode_cfg_pkg::wave_src_t waveform_source,
	output      logic                    waveform_source_valid
);
	import mode_cfg_pkg::*;

	logic                 sclk_m, sclk_s, sclk_p;
	logic                 din_m, din_s;
	logic                 cs_n_m, cs_n_s;
	logic                 rise;
	ser_state_t           state_q, state_d;
	logic [CNT_W-1:0]     cnt_q, cnt_d;
	logic [DATA_BITS-1:0] shin_q, shin_d;
	logic [DATA_BITS-1:0] shout_q, shout_d;
	logic [DATA_BITS-1:0] mode_q, mode_d;
	logic [QUIET_W-1:0]   quiet_q, quiet_d;
	logic                 pulse_q, pulse_d;
	logic                 dip_q, dip_d;
	logic [DATA_BITS-1:0] wdata;
	logic [CMD_BITS-1:0]  cmd;
	logic                 commit;

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_p <= 1'b0;
			din_m  <= 1'b0;
			din_s  <= 1'b0;
			cs_n_m <= 1'b1;
			cs_n_s <= 1'b1;
		end else begin
			sclk_m <= sclk;
			sclk_s <= sclk_m;
			sclk_p <= sclk_s;
			din_m  <= din;
			din_s  <= din_m;
			cs_n_m <= cs_n;
			cs_n_s <= cs_n_m;
		end
	end

	assign rise  = sclk_s && !sclk_p;
	assign wdata = {shin_q[DATA_BITS-2:0], din_s};
	assign cmd   = wdata[CMD_BITS-1:0];

	////////////////////////////////////////////////////////////////
	// serial framing, mode register, soft reset quiet time
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		shin_d  = shin_q;
		shout_d = shout_q;
		mode_d  = mode_q;
		quiet_d = quiet_q;
		commit  = 1'b0;
		if (temp_conv_done) begin
			mode_d[THERM_GO_BIT] = 1'b0;
		end
		if (quiet_q != '0) begin
			quiet_d = QUIET_W'(quiet_q - 1'b1);
			state_d = ST_CMD;
			cnt_d   = '0;
		end else if (cs_n_s) begin
			state_d = ST_CMD;
			cnt_d   = '0;
		end else if (rise) begin
			shin_d = wdata;
			cnt_d  = CNT_W'(cnt_q + 1'b1);
			case (state_q)
				ST_CMD: begin
					if (cnt_q == CNT_W'(CMD_BITS - 1)) begin
						cnt_d = '0;
						if (cmd[CMD_ADDR_MSB:0] != MODE_ADDR) begin
							state_d = ST_SKIP;
						end else if (cmd[CMD_DIR_BIT]) begin
							state_d = ST_WRITE;
						end else begin
							state_d = ST_READ;
							shout_d = mode_q & STORE_MASK;
						end
					end
				end
				ST_WRITE: begin
					if (cnt_q == CNT_W'(DATA_BITS - 1)) begin
						commit  = 1'b1;
						state_d = ST_SKIP;
						mode_d  = wdata & STORE_MASK;
						if (wdata[SOFT_RST_BIT]) begin
							mode_d  = MODE_RESET;
							quiet_d = QUIET_W'(QUIET_CYCLES);
						end
					end
				end
				ST_READ: begin
					shout_d = {shout_q[DATA_BITS-2:0], 1'b0};
					if (cnt_q == CNT_W'(DATA_BITS - 1)) begin
						state_d = ST_SKIP;
					end
				end
				ST_SKIP: cnt_d = cnt_q;
				default: state_d = ST_CMD;
			endcase
		end
		// gated event outputs
		pulse_d = pulse_raw && !mode_q[PULSE_OFF_BIT];
		dip_d   = dip_raw && !mode_q[DIP_OFF_BIT];
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= ST_CMD;
			cnt_q   <= '0;
			shin_q  <= '0;
			shout_q <= '0;
			mode_q  <= MODE_RESET;
			quiet_q <= '0;
			pulse_q <= 1'b0;
			dip_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			shin_q  <= shin_d;
			shout_q <= shout_d;
			mode_q  <= mode_d;
			quiet_q <= quiet_d;
			pulse_q <= pulse_d;
			dip_q   <= dip_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs: serial read data, gated events, soft reset quiet flag and mode register fields
	assign dout                = shout_q[DATA_BITS-1];
	assign dout_oe             = (state_q == ST_READ) && !cs_n_s;
	assign frequency_pulse_out = pulse_q;
	assign dip_event           = dip_q;
	assign ch1_highpass_bypass = mode_q[HPF_BYP_BIT];
	assign pulse_output_off    = mode_q[PULSE_OFF_BIT];
	assign dip_detect_off      = mode_q[DIP_OFF_BIT];
	assign thermal_conv_go     = mode_q[THERM_GO_BIT];
	assign soft_chip_reset     = (quiet_q != '0);
	assign calibration_select  = mode_q[CAL_SEL_BIT];
	assign conv1_input_short   = mode_q[SHORT1_BIT];
	assign conv2_input_short   = mode_q[SHORT2_BIT];
	assign input_swap          = mode_q[SWAP_BIT];
	assign factory_bit_low     = mode_q[FACT_LO_BIT];
	assign factory_bit_high    = mode_q[FACT_HI_BIT];
	assign waveform_rate_sel   = mode_q[RATE_LSB +: 2];
	assign waveform_source_sel = mode_q[SRC_LSB +: 2];

	////////////////////////////////////////////////////////////////
	// waveform timing
	wave_ctl_if wv ();

	assign wv.rate_sel           = waveform_rate_sel;
	assign wv.source_sel         = waveform_source_sel;
	assign waveform_sample_stb   = wv.sample_stb;
	assign waveform_source       = wv.source;
	assign waveform_source_valid = wv.source_valid;

	wave_timer u_wave (
		.clk  (clk),
		.rstn (rstn),
		.wv   (wv)
	);

	////////////////////////////////////////////////////////////////
	// checks
	hpf_bypass_a: assert property (@(posedge clk) disable iff (!rstn)
		commit && !wdata[SOFT_RST_BIT] |=> ch1_highpass_bypass == $past(wdata[HPF_BYP_BIT]))
		else $error("filter bypass not written");
	pulse_off_a: assert property (@(posedge clk) disable iff (!rstn)
		pulse_output_off |=> !frequency_pulse_out) else $error("pulse while disabled");
	dip_off_a: assert property (@(posedge clk) disable iff (!rstn)
		dip_detect_off |=> !dip_event) else $error("dip while disabled");
	therm_clear_a: assert property (@(posedge clk) disable iff (!rstn)
		temp_conv_done && !commit |=> !thermal_conv_go) else $error("conversion bit stuck");
	soft_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
		commit && wdata[SOFT_RST_BIT] |=> (soft_chip_reset && mode_q == MODE_RESET
		&& !dout_oe) [*8]) else $error("soft reset quiet wrong");
	cal_mode_a: assert property (@(posedge clk) disable iff (!rstn)
		commit && !wdata[SOFT_RST_BIT] |=> calibration_select == $past(wdata[CAL_SEL_BIT]))
		else $error("calibration bit not written");
	input_ctl_a: assert property (@(posedge clk) disable iff (!rstn)
		commit && !wdata[SOFT_RST_BIT] |=> {input_swap, conv2_input_short, conv1_input_short}
		== $past(wdata[SWAP_BIT:SHORT1_BIT])) else $error("input control not written");
	read_first_a: assert property (@(posedge clk) disable iff (!rstn)
		rise && !cs_n_s && quiet_q == '0 && state_q == ST_CMD && cnt_q == CNT_W'(CMD_BITS - 1)
		&& cmd == {3'b000, MODE_ADDR} |=> dout_oe && dout == $past(mode_q[FACT_HI_BIT]))
		else $error("read data not presented");
	reserved_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		(mode_q & ~STORE_MASK) == '0) else $error("unstored bit held");

	write_cov: cover property (@(posedge clk) disable iff (!rstn) commit);
	read_cov: cover property (@(posedge clk) disable iff (!rstn) $rose(dout_oe));
	soft_chip_reset_cov: cover property (@(posedge clk) disable iff (!rstn) $fell(soft_chip_reset));
	therm_cov: cover property (@(posedge clk) disable iff (!rstn) $fell(thermal_conv_go));
endmodule // energy_meter_mode_config

// File: dv/host_model.sv
`timescale 1ns/1ps
module host_model (
	input  wire logic clk,
	input  wire logic dout,
	input  wire logic dout_oe,
	output      logic sclk,
	output      logic din,
	output      logic cs_n
);
	// serial lines idle with clock still and chip deselected
	initial begin
		sclk = 1'b0;
		din  = 1'b0;
		cs_n = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one frame: command byte then 16 data bits, msb first, 4 clk per phase
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
		output logic [15:0] rd, output logic oe_seen);
		logic [23:0] sh;
		sh      = {cmd, wd & 16'h7fed};
		rd      = 16'h0000;
		oe_seen = 1'b0;
		cs_n <= 1'b0;
		hold(4);
		for (int i = 23; i >= 0; i--) begin
			din <= sh[i];
			hold(4);
			// sample before the rise that shifts the next bit
			if (i < 16) begin
				rd      = {rd[14:0], dout};
				oe_seen = oe_seen | dout_oe;
			end
			sclk <= 1'b1;
			hold(4);
			sclk <= 1'b0;
		end
		hold(4);
		cs_n <= 1'b1;
		din  <= ~din; // no stale level after release
		hold(6);
	endtask
endmodule // host_model

// File: dv/test_energy_meter_mode_config.sv
`timescale 1ns/1ps
module test_energy_meter_mode_config;
	import mode_cfg_pkg::*;
	logic            clk = 1'b0;
	logic            rstn = 1'b0;
	logic            pulse_raw = 1'b0;
	logic            dip_raw = 1'b0;
	logic            temp_conv_done = 1'b0;
	wire logic       sclk, din, cs_n, dout, dout_oe;
	logic            freq_out, dip_event, srst, stb, src_valid;
	wire logic [15:0] mo;
	wave_src_t       src;
	int              error_cnt = 0;
	int              check_count = 0;
	int              srst_cnt = 0;
	localparam logic [15:0] field_tbl [14] = '{16'h0001, 16'h0004, 16'h0008, 16'h0080,
		16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h1800, 16'h2000, 16'h4000,
		16'h6000, 16'h0000};

	assign mo[4] = 1'b0;
	assign mo[6] = 1'b0;
	always #5 clk = ~clk;
	always @(posedge clk) if (srst === 1'b1) srst_cnt <= srst_cnt + 1;

	energy_meter_mode_config i_dut (.clk(clk), .rstn(rstn), .sclk(sclk), .din(din),
		.cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .pulse_raw(pulse_raw),
		.frequency_pulse_out(freq_out), .dip_raw(dip_raw), .dip_event(dip_event),
		.temp_conv_done(temp_conv_done), .ch1_highpass_bypass(mo[0]),
		.pulse_output_off(mo[2]), .dip_detect_off(mo[3]), .thermal_conv_go(mo[5]),
		.soft_chip_reset(srst), .calibration_select(mo[7]), .conv1_input_short(mo[8]),
		.conv2_input_short(mo[9]), .input_swap(mo[10]), .factory_bit_low(mo[1]),
		.factory_bit_high(mo[15]), .waveform_rate_sel(mo[12:11]),
		.waveform_source_sel(mo[14:13]), .waveform_sample_stb(stb),
		.waveform_source(src), .waveform_source_valid(src_valid));
	host_model i_host (.clk(clk), .dout(dout), .dout_oe(dout_oe), .sclk(sclk), .din(din),
		.cs_n(cs_n));

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic xfer(input logic [7:0] c, input logic [15:0] w, output logic [15:0] r,
		output logic o);
		@(posedge clk);
		i_host.xfer(c, w, r, o);
	endtask

	task automatic wr(input logic [15:0] v);
		logic [15:0] r;
		logic        o;
		xfer(8'h86, v, r, o);
	endtask

	task automatic rd_chk(input string nm, input logic [15:0] exp);
		logic [15:0] r;
		logic        o;
		xfer(8'h06, 16'h0000, r, o);
		chk(nm, r, exp);
		chk("read_oe", 16'(o), 16'h0001);
	endtask

	// counts cycles up to and including the next strobe
	task automatic wait_stb(output int n);
		n = 0;
		do begin
			tick(1);
			n++;
		end while (stb !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			error_cnt++;
			print_verdict();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk("mode_out", mo, 16'h0000);
		chk("src_valid", 16'(src_valid), 16'h0001);
		rd_chk("reset_read", 16'h0000);
	endtask

	// each field except thermal go, soft reset and the factory bits, alone, with the raw pulse and dip toggled against the gates
	task automatic t_fields;
		logic [15:0] v;
		for (int i = 0; i < 14; i++) begin
			v = field_tbl[i];
			@(posedge clk);
			pulse_raw <= i[0];
			dip_raw   <= ~i[0];
			wr(v);
			tick(1);
			chk("mode_out", mo, v);
			chk("pulse", 16'(freq_out), 16'(i[0] && !v[2]));
			chk("dip", 16'(dip_event), 16'(!i[0] && !v[3]));
			chk("source", 16'(src), 16'(v[14:13]));
			chk("src_valid", 16'(src_valid), 16'(v[14:13] != 2'b01));
			rd_chk("readback", v);
		end
	endtask

	task automatic t_rate;
		int n;
		for (int c = 0; c < 4; c++) begin
			wr(16'(c) << 11);
			wait_stb(n);
			wait_stb(n);
			chk("rate_period", 16'(n), 16'(128 << c));
		end
	endtask

	task automatic t_thermal;
		wr(16'h0020);
		tick(1);
		chk("therm_go", 16'(mo[5]), 16'h0001);
		@(posedge clk) temp_conv_done <= 1'b1;
		@(posedge clk) temp_conv_done <= 1'b0;
		tick(2);
		chk("therm_done", 16'(mo[5]), 16'h0000);
		rd_chk("therm_read", 16'h0000);
	endtask

	task automatic t_unmapped;
		logic [15:0] r;
		logic        o;
		xfer(8'h07, 16'h0000, r, o);
		chk("oe_unmapped", 16'(o), 16'h0000);
		xfer(8'h87, 16'h0001, r, o);
		chk("mode_out", mo, 16'h0000);
	endtask

	task automatic t_softreset;
		int n;
		int base;
		wr(16'h0781);
		base = srst_cnt;
		wr(16'h0040);
		tick(1);
		chk("cleared", mo, 16'h0000);
		n = 0;
		// host stays quiet until the reset window has run out
		while (srst === 1'b1 && n < 2500) begin
			tick(1);
			n++;
		end
		// a reset window that never closes ends the run
		if (n >= 2500) begin
			error_cnt++;
			print_verdict();
		end
		tick(2);
		chk("quiet_cycles", 16'(srst_cnt - base), 16'(1800));
		rd_chk("after_reset", 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		tick(6);
		t_reset();
		t_fields();
		t_rate();
		t_thermal();
		t_unmapped();
		t_softreset();
		print_verdict();
	end
endmodule // test_energy_meter_mode_config
